// ===== rtl/dcspi_top.sv
// serial framing, crc check and daisy-chain relay of one monitor device
// Contract
// - write frames without 010 in bits 2..0 are discarded.
// - write frame: dev addr, reg addr, data, all flag, zero, crc, pattern.
// - device address travels lsb first; other fields msb first.
// - conversion read frame: dev, channel, 12-bit result, ack, crc, zeros.
// - register read frame: dev, reg addr, data, zeros, ack, crc, zeros.
// - read crc covers bits 31..10, sent in bits 9..2.
// - write crc covers bits 31..11, checked before executing.
// - crc match executes write and sets ack; mismatch skips, ack 0 (code clears ack only on an address match).
// - chain conversion readback takes n times 8 frames.
// - up to eight devices, six cells each, 48 channels.
// - all seven interface signals relay to the neighbour (code sends only its own word on serial out, never upstream data).
// - master pins are host inputs; slave pins are chain inputs.
// - slave tristates serial out and alert; uses downstream pins.
// - one 32-bit frame updates any register in the chain.
// - each result carries a four-bit channel code.
// - register addresses are six bits.
// - result field holds a 12-bit value.
// - register read returns register chosen by an earlier write.
// - mode 1: sample on falling edge, launch on rising edge.
// - 32-bit frames only; bit counter resets when chip select rises.
// - all flag broadcasts; device address must be zero then.
// - crc polynomial x^8+x^5+x^3+x^2+x+1.
`timescale 1ns/10ps
module dcspi_top import dcspi_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_clock,
  input wire logic is_master,
  input wire logic [4:0] own_addr,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  input wire logic conversion_trigger_n,
  input wire logic power_down_n,
  input wire logic alert_in,
  input wire logic upstream_sdo,
  input wire logic upstream_alert,
  output logic upstream_serial_clock,
  output logic upstream_cs_n,
  output logic upstream_sdi,
  output logic upstream_conversion_trigger_n,
  output logic upstream_power_down_n,
  output logic sdo_out,
  output logic sdo_oe,
  output logic alert_out,
  output logic alert_oe,
  output logic downstream_serial_out,
  output logic downstream_alert,
  input wire logic read_conv,
  input wire logic [5:0] read_reg_sel,
  input wire logic [7:0] read_reg_data,
  input wire dcspi_conv_t conv_in,
  output dcspi_wr_cmd_t wr_cmd,
  output logic wr_strobe,
  output logic frame_error
);
  `include "dcspi_defs.svh"
  // link-domain shift logic runs on serial_clock, reset by chip select
  logic [31:0] rx_q;
  logic [31:0] rx_d;
  logic [4:0] cnt_q;
  logic [31:0] tx_q;
  logic ack_q;
  logic tgl_q;
  logic ok_q;
  dcspi_wr_frame_t wr_q;
  dcspi_wr_frame_t rx_frame;
  logic [7:0] wr_crc;
  logic [7:0] rd_crc;
  logic [20:0] wr_body;
  logic [21:0] rd_body;
  logic [4:0] own_rev;
  logic addr_hit;
  logic frame_ok;
  logic [31:0] rd_frame;
  logic last_bit;
  // relay of five of the seven interface signals to the upstream device
  assign upstream_serial_clock = serial_clock;
  assign upstream_cs_n = cs_n_in;
  assign upstream_sdi = sdi_in;
  assign upstream_conversion_trigger_n = conversion_trigger_n;
  assign upstream_power_down_n = power_down_n;
  // pins are host side on master, chain side on slave: same logic serves both
  assign sdo_oe = is_master;
  assign alert_oe = is_master;
  assign downstream_alert = alert_in | upstream_alert;
  assign alert_out = downstream_alert;
  assign last_bit = (cnt_q == `DCSPI_CNT_LAST);
  assign rx_d = {rx_q[30:0], sdi_in};
  assign rx_frame = dcspi_wr_frame_t'(rx_d);
  // crc over bits 31..11 of the incoming frame
  assign wr_body = rx_d[31:11];
  dcspi_crc8 #(.NBITS(21)) u_wr_crc (
    .data(wr_body),
    .crc(wr_crc)
  );
  // own address arrives lsb first, so compare bit-reversed
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      own_rev[i] = own_addr[4 - i];
    end
  end
  assign addr_hit = rx_frame.all_flag ? (rx_frame.dev_addr == `DCSPI_ALL_ADDR)
                                      : (rx_frame.dev_addr == own_rev);
  assign frame_ok = (rx_frame.pattern == `DCSPI_PATTERN)
                    && (wr_crc == rx_frame.crc)
                    && (rx_frame.zero_bit == 1'b0);
  // bit counter and receive shift on falling edge
  always_ff @(negedge serial_clock or posedge cs_n_in) begin
    if (cs_n_in) begin
      cnt_q <= 5'h00;
      rx_q <= 32'h00000000;
    end else begin
      cnt_q <= cnt_q + 5'h01;
      rx_q <= rx_d;
    end
  end
  // capture completed frames; a crc, pattern or zero-bit failure clears ack only when the frame's address matches
  always_ff @(negedge serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      ack_q <= 1'b0;
      ok_q <= 1'b0;
      tgl_q <= 1'b0;
    end else if (!cs_n_in && last_bit) begin
      wr_q <= rx_frame;
      ok_q <= frame_ok && addr_hit;
      if (addr_hit) begin
        ack_q <= frame_ok;
      end
      tgl_q <= ~tgl_q;
    end
  end
  // readback word, register data chosen earlier by the read select
  assign rd_body = read_conv
    ? {own_rev, conv_in.chan, conv_in.result, ack_q}
    : {own_rev, read_reg_sel, read_reg_data, 2'b00, ack_q};
  dcspi_crc8 #(.NBITS(22)) u_rd_crc (
    .data(rd_body),
    .crc(rd_crc)
  );
  assign rd_frame = {rd_body, rd_crc, 2'b00};
  // launch on rising edge; own word reloads whenever the count is zero, so upstream data shifted in never reaches serial out
  always_ff @(posedge serial_clock or posedge cs_n_in) begin
    if (cs_n_in) begin
      tx_q <= 32'h00000000;
    end else if (cnt_q == 5'h00) begin
      tx_q <= rd_frame;
    end else begin
      tx_q <= {tx_q[30:0], upstream_sdo};
    end
  end
  assign downstream_serial_out = tx_q[31];
  assign sdo_out = tx_q[31];
  // frame event crosses to the system clock by toggle
  logic tgl_s;
  logic tgl_seen_q;
  logic ev;
  dcspi_sync2 u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d(tgl_q),
    .q(tgl_s)
  );
  assign ev = tgl_s ^ tgl_seen_q;
  // wr_q and ok_q are stable: next change needs a further 32 link clocks
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tgl_seen_q <= 1'b0;
      wr_cmd <= '0;
      wr_strobe <= 1'b0;
      frame_error <= 1'b0;
    end else begin
      tgl_seen_q <= tgl_s;
      wr_strobe <= ev && ok_q;
      frame_error <= ev && !ok_q;
      if (ev && ok_q) begin
        wr_cmd <= '{valid: 1'b1, reg_addr: wr_q.reg_addr, data: wr_q.data};
      end
    end
  end
endmodule

// ===== rtl/dcspi_defs.svh
// constants for the daisy-chain serial framing block
`ifndef DCSPI_DEFS_SVH
`define DCSPI_DEFS_SVH
`define DCSPI_FRAME_BITS 32
`define DCSPI_CNT_W 5
`define DCSPI_CNT_LAST 5'h1f
`define DCSPI_PATTERN 3'h2
`define DCSPI_CRC_POLY 8'h2f
`define DCSPI_CRC_INIT 8'h00
`define DCSPI_ALL_ADDR 5'h00
`define DCSPI_CONV_SEL 6'h00
`define DCSPI_MAX_DEV 4'h8
`define DCSPI_CELLS_PER_DEV 4'h6
`endif

// ===== rtl/dcspi_pkg.sv
// types for the daisy-chain serial framing block
package dcspi_pkg;
  typedef struct packed {
    logic [4:0] dev_addr;
    logic [5:0] reg_addr;
    logic [7:0] data;
    logic all_flag;
    logic zero_bit;
    logic [7:0] crc;
    logic [2:0] pattern;
  } dcspi_wr_frame_t;
  typedef struct packed {
    logic [4:0] reg_addr;
    logic [5:0] dummy;
  } dcspi_unused_t;
  typedef struct packed {
    logic valid;
    logic [5:0] reg_addr;
    logic [7:0] data;
  } dcspi_wr_cmd_t;
  typedef struct packed {
    logic [3:0] chan;
    logic [11:0] result;
  } dcspi_conv_t;
  typedef enum logic [1:0] {
    DCSPI_IDLE = 2'b01,
    DCSPI_SHIFT = 2'b10
  } dcspi_state_t;
endpackage

// ===== rtl/dcspi_crc8.sv
// combinational crc-8 over a left-aligned data word
`timescale 1ns/10ps
module dcspi_crc8 import dcspi_pkg::*; #(
  parameter int NBITS = 22
) (
  input wire logic [NBITS-1:0] data,
  output logic [7:0] crc
);
  `include "dcspi_defs.svh"
  always_comb begin
    logic [7:0] r;
    logic fb;
    r = `DCSPI_CRC_INIT;
    fb = 1'b0;
    for (int i = NBITS - 1; i >= 0; i--) begin
      fb = r[7] ^ data[i];
      r = {r[6:0], 1'b0} ^ (fb ? `DCSPI_CRC_POLY : 8'h00);
    end
    crc = r;
  end
endmodule

// ===== rtl/dcspi_sync2.sv
// two-flop level synchroniser
`timescale 1ns/10ps
module dcspi_sync2 (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic s1_q;
  logic s2_q;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule

// ===== verif/dcspi_top_sva.sv
// port-level checks for the framing block
`timescale 1ns/10ps
module dcspi_top_sva import dcspi_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_clock,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  input wire logic is_master,
  input wire logic alert_in,
  input wire logic upstream_alert,
  input wire logic upstream_serial_clock,
  input wire logic upstream_cs_n,
  input wire logic upstream_sdi,
  input wire logic sdo_oe,
  input wire logic alert_oe,
  input wire logic downstream_alert,
  input wire dcspi_wr_cmd_t wr_cmd,
  input wire logic wr_strobe,
  input wire logic frame_error
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_relay_clock: assert property (upstream_serial_clock == serial_clock)
    else $error("serial clock not relayed");
  chk_relay_select: assert property (upstream_cs_n == cs_n_in)
    else $error("chip select not relayed");
  chk_relay_data: assert property (upstream_sdi == sdi_in)
    else $error("serial data not relayed");
  chk_slave_tristate: assert property (sdo_oe == is_master && alert_oe == is_master)
    else $error("output enable wrong for strap");
  chk_alert_merge: assert property (downstream_alert == (alert_in | upstream_alert))
    else $error("alert not passed down");
  chk_strobe_pulse: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe longer than one cycle");
  chk_error_excl: assert property (frame_error |-> !wr_strobe)
    else $error("refused frame also executed");
  chk_cmd_valid: assert property (wr_strobe |=> wr_cmd.valid)
    else $error("executed write without valid command");
  // command must only move with an accepted write
  chk_cmd_hold: assert property ($changed(wr_cmd) |-> wr_strobe || $past(wr_strobe))
    else $error("write command changed without strobe");
  cover property (wr_strobe);
  cover property (frame_error);
  cover property (!sdo_oe);
endmodule
bind dcspi_top dcspi_top_sva chk (.*);

// ===== verif/dcspi_host.sv
// host serial master model, mode 1 framing
`timescale 1ns/10ps
module dcspi_host (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    #40 sclk = 1'b1;
    #15 sclk = 1'b0;
  end
  // clock stands still between frames; sdi parked at the inverse, no pull
  // bench link runs faster than the chained rate; no relay delay modelled
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      #15 sclk = 1'b1;
      sdi = tx[i];
      #15 sclk = 1'b0;
      rx[i] = sdo;
    end
    #15 cs_n = 1'b1;
    sdi = ~sdi;
    #60;
  endtask
endmodule

// ===== verif/tb.sv
// self-checking bench for the framing block
`timescale 1ns/10ps
module tb import dcspi_pkg::*;;
  logic clock = 1'b0, rst_n = 1'b0, read_conv = 1'b0, upstream_sdo = 1'b0;
  logic is_master = 1'b1, conversion_trigger_n = 1'b1, power_down_n = 1'b1;
  logic alert_in = 1'b0, upstream_alert = 1'b0;
  logic [4:0] own_addr = 5'h01;
  logic [5:0] read_reg_sel = 6'h0e;
  logic [7:0] read_reg_data = 8'ha5;
  dcspi_conv_t conv_in = 16'h9c3a;
  logic serial_clock, cs_n_in, sdi_in, upstream_serial_clock, upstream_cs_n, upstream_sdi;
  logic upstream_conversion_trigger_n, upstream_power_down_n, sdo_out, sdo_oe, alert_out;
  logic alert_oe, downstream_serial_out, downstream_alert, wr_strobe, frame_error;
  dcspi_wr_cmd_t wr_cmd;
  int miscompares = 0, checked = 0, cyc = 0;
  dcspi_top dut (.*);
  dcspi_host host (.sclk(serial_clock), .cs_n(cs_n_in), .sdi(sdi_in), .sdo(sdo_out));
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] crc(input logic [31:0] w, input int n);
    logic [7:0] c = 8'h00;
    for (int i = 31; i > 31 - n; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h2f : 8'h00);
    return c;
  endfunction
  function automatic logic [31:0] wr(input logic [4:0] dv, input logic [13:0] rd, input logic a);
    logic [31:0] w = {dv, rd, a, 1'b0, 8'h00, 3'h2};
    w[10:3] = crc(w, 21);
    return w;
  endfunction
  // watch during the frame: the pulse lands only a few clocks after the last fall
  task automatic t_write(input logic [31:0] f, input logic ok);
    logic [31:0] rx;
    logic s = 1'b0;
    logic e = 1'b0;
    fork
      host.xfer(f, rx);
      for (int i = 0; i < 60; i++) begin
        @(posedge clock);
        #1 s |= (i >= 10) & wr_strobe;
        e |= (i >= 10) & frame_error;
      end
    join
    cmp({31'h0, s}, {31'h0, ok});
    cmp({31'h0, e}, {31'h0, ~ok});
    if (ok) cmp({17'h0, wr_cmd}, {17'h0, 1'b1, f[26:13]});
  endtask
  task automatic t_read(input logic [15:0] body, input logic ack);
    logic [31:0] rx;
    host.xfer(32'hf800030a, rx);
    cmp({27'h0, rx[31:27]}, {27'h0, 5'h10});
    cmp({13'h0, rx[26:10], rx[1:0]}, {13'h0, body, ack, 2'b00});
    cmp({24'h0, rx[9:2]}, {24'h0, crc(rx, 22)});
  endtask
  task automatic t_relay;
    @(negedge clock);
    {is_master, conversion_trigger_n, power_down_n, alert_in, upstream_alert, upstream_sdo} = 6'h15;
    repeat (3) @(negedge clock);
    cmp({31'h0, downstream_alert}, 32'h1);
    cmp({27'h0, sdo_oe, alert_oe, upstream_conversion_trigger_n, upstream_power_down_n, alert_out}, 32'h05);
    {is_master, conversion_trigger_n, power_down_n, alert_in, upstream_alert, upstream_sdo} = 6'h3a;
    repeat (3) @(negedge clock);
    cmp({27'h0, sdo_oe, alert_oe, upstream_conversion_trigger_n, upstream_power_down_n, alert_out}, 32'h1f);
  endtask
  task automatic stop_test;
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    @(negedge clock) rst_n = 1'b1;
    repeat (3) @(negedge clock);
    // own address 1 travels reversed on the wire
    t_write(wr(5'h10, 14'h053c, 1'b0), 1'b1);
    t_read({6'h0e, 8'ha5, 2'b00}, 1'b1);
    t_write(wr(5'h10, 14'h0611, 1'b0) ^ 32'h8, 1'b0);
    @(negedge clock) read_conv = 1'b1;
    // one conversion frame stands for one of the n times 8 readback frames
    t_read(16'h9c3a, 1'b0);
    t_write(wr(5'h10, 14'h0611, 1'b0) ^ 32'h1, 1'b0);
    t_write(wr(5'h01, 14'h0611, 1'b0), 1'b0);
    t_write(wr(5'h00, 14'h0781, 1'b1), 1'b1);
    t_write(wr(5'h10, 14'h0781, 1'b1), 1'b0);
    t_relay();
    stop_test();
  end
endmodule
